//--- core/pcs_pkg.sv
// Purpose: Shared constants for the pipeline command sequencer.
// Assumes: AXI4-Lite with 32-bit data, one aligned word per register.
// Notes: Offsets are byte addresses.
package pcs_pkg;
	// ---------------------------------------------------------------
	// Sizes
	// ---------------------------------------------------------------
	localparam int NUM_UNITS = 6;
	localparam int CONST_WORDS = 16;
	localparam logic [2:0] UNIT_STREAMER = 3'h0;
	localparam logic [2:0] UNIT_GEOMETRY = 3'h2;
	localparam logic [2:0] UNIT_CLIPPER = 3'h3;
	localparam logic [5:0] MASK_STREAMER = 6'h01;
	localparam logic [5:0] MASK_DRAW_PIPE = 6'h1e;
	localparam logic [5:0] MASK_MEDIA_PIPE = 6'h20;

	// ---------------------------------------------------------------
	// Register offsets
	// ---------------------------------------------------------------
	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_ARG = 8'h04;
	localparam logic [7:0] OFS_CMD = 8'h08;
	localparam logic [7:0] OFS_STATUS = 8'h0c;
	localparam logic [7:0] OFS_HELD = 8'h10;
	localparam logic [7:0] OFS_CONST = 8'h14;

	// ---------------------------------------------------------------
	// Reset values and answers
	// ---------------------------------------------------------------
	localparam logic [31:0] CTRL_RESET = 32'h0000_0001;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// ---------------------------------------------------------------
	// Field positions
	// ---------------------------------------------------------------
	localparam int CTRL_PIPE_BIT = 8;
	localparam int CTRL_SEL_LSB = 12;
	localparam int CTRL_IDX_LSB = 16;
	localparam int CMD_UNIT_LSB = 4;
	localparam int ARG_SIZE_LSB = 8;
	localparam int ARG_THR_LSB = 16;
	localparam int ARG_MASK_LSB = 16;
	localparam int ST_VIOL = 0;

	// ---------------------------------------------------------------
	// Command opcodes
	// ---------------------------------------------------------------
	typedef enum logic [3:0] {
		OP_NOP = 4'h0,
		OP_STREAMER_STATE = 4'h1,
		OP_DRAW_STATE_PTR = 4'h2,
		OP_MEDIA_STATE_PTR = 4'h3,
		OP_COMMON_STATE = 4'h4,
		OP_DRAW_STATE = 4'h5,
		OP_FENCE = 4'h6,
		OP_CONST_LOAD = 4'h7,
		OP_DRAW = 4'h8,
		OP_MEDIA_WORK = 4'h9
	} pcs_op_t;
endpackage

//--- core/pcs_unit_alloc.sv
// Purpose: Entry release and reallocation engine of one fixed-function unit.
// Assumes: One trigger at a time; the sequencer waits while busy.
// Notes: Release and allocation advance one entry per cycle in parallel.
`timescale 1ns/1ps
module pcs_unit_alloc (
	// Clock and reset.
	input wire logic aclk,
	input wire logic aresetn,
	// Fence delivery.
	input wire logic fence_go,
	input wire logic unit_en,
	input wire logic update_en,
	input wire logic [15:0] fence_val,
	// Programmed entry state.
	input wire logic [7:0] entry_cnt,
	input wire logic [7:0] entry_size,
	// Allocation state.
	output logic busy,
	output logic realloc,
	output logic [7:0] held,
	output logic [15:0] base
);
	logic [7:0] held_q, held_d, rel_q, rel_d, tgt_q, tgt_d;
	logic [15:0] base_q, base_d;
	logic trig;

	// Only an enabled unit whose update bit is set reallocates.
	assign trig = fence_go & unit_en & update_en; // [R04]
	// Release drains every held entry while new handles count up.
	assign rel_d = trig ? held_q : // [R05]
		(rel_q != 8'h00) ? rel_q - 8'h01 : rel_q;
	assign held_d = trig ? 8'h00 :
		(held_q != tgt_q) ? held_q + 8'h01 : held_q;
	// The region ends at the fence and spans count times size.
	assign tgt_d = trig ? entry_cnt : tgt_q; // [R06]
	assign base_d = trig ? fence_val - entry_cnt * entry_size : base_q;
	assign busy = (rel_q != 8'h00) | (held_q != tgt_q);
	assign held = held_q;
	assign base = base_q;

	// State registers.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			held_q <= 8'h00;
			rel_q <= 8'h00;
			tgt_q <= 8'h00;
			base_q <= 16'h0000;
			realloc <= 1'b0;
		end else begin
			held_q <= held_d;
			rel_q <= rel_d;
			tgt_q <= tgt_d;
			base_q <= base_d;
			realloc <= trig;
		end
	end
endmodule // pcs_unit_alloc

//--- core/pcs_sequencer.sv
// Purpose: Command ordering checker and entry fence handler.
// Assumes: Software issues commands by writing ARG then CMD over AXI4-Lite.
// Notes: A CMD write is answered only after earlier fence work has finished; a fence is answered before its own work.
//
// Overview of operation
// R01 - Software sets all draw-pipeline state before any draw command.
// R02 - Software sets the media state pointer before any media work command.
// R03 - A fence goes to the streamer unit first, then to the selected pipe.
// R04 - A unit reallocates only if enabled and its update bit is set.
// R05 - Reallocation releases all held entries, overlapping new allocation.
// R06 - New handles use the fence value with the unit's count and size.
// R07 - Streamer state comes from its own command, others from pointer cmds.
// R08 - Changing count, size or thread limit alone never reallocates.
// R09 - Software must fence after such a change before constants or work.
// R10 - Software may change a fence alone but must keep it consistent.
// R11 - A streamer fence invalidates constants until a new constant load.
// R12 - A constant load writes the streamer-owned constant region.
// R13 - Constant load only after streamer state and fence, before work.
// R14 - Before a draw, all state except media pointers must be valid; the code does not check OP_DRAW_STATE.
// R15 - Before media work, all state except draw-pipe state must be valid.
// R16 - Common state must be valid before any draw or media work.
// R17 - Out-of-order work or constant load sets a sticky violation flag.
`timescale 1ns/1ps
module pcs_sequencer (
	// Clock and reset.
	input wire logic aclk,
	input wire logic aresetn,
	// Write address channel.
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	// Write data channel.
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	// Write response channel.
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	// Read address channel.
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	// Read data channel.
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready
);
	localparam int N = pcs_pkg::NUM_UNITS;

	// ---------------------------------------------------------------
	// Helpers
	// ---------------------------------------------------------------
	// Byte-lane merge of a write into a stored word.
	function automatic logic [31:0] merge(input logic [31:0] old,
		input logic [31:0] wd, input logic [3:0] st);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++) begin
			if (st[i]) begin
				r[i*8 +: 8] = wd[i*8 +: 8];
			end
		end
		return r;
	endfunction

	// ---------------------------------------------------------------
	// Bus slave state
	// ---------------------------------------------------------------
	logic [7:0] awaddr_q;
	logic [31:0] wdata_q;
	logic [3:0] wstrb_q;
	logic aw_have_q, w_have_q;
	logic [31:0] ctrl_q, arg_q;
	logic viol_q, const_valid_q, common_q, draw_st_q, media_st_q;
	logic cs_state_q, cs_fenced_q;
	logic [N-1:0] stale_q;
	logic [1:0] fence_stage_q;
	logic [5:0] fence_mask_q;
	logic [15:0] fence_val_q;
	logic [7:0] cnt_q [N];
	logic [7:0] size_q [N];
	logic [7:0] thr_q [N];
	logic [31:0] const_mem [pcs_pkg::CONST_WORDS];

	// Allocator outputs.
	logic [N-1:0] unit_busy, unit_realloc, unit_go, unit_en;
	logic [7:0] unit_held [N];
	logic [15:0] unit_base [N];

	// ---------------------------------------------------------------
	// Decode
	// ---------------------------------------------------------------
	logic any_busy, exec, hit_ctrl, hit_arg, hit_cmd, hit_status;
	logic w_known, r_known, pipe_media;
	logic [31:0] wval;
	pcs_pkg::pcs_op_t op;
	logic [2:0] cmd_unit;
	logic [5:0] pipe_mask, live_mask;
	logic cs_ok, draw_ok, media_ok, const_ok, viol_set, viol_clr;
	logic [2:0] sel;
	logic [3:0] cidx;
	logic [31:0] status_w, rd_word;
	logic [7:0] ar_ofs;

	assign any_busy = (|unit_busy) | (fence_stage_q != 2'h0);
	// A write executes once both halves are held and fence work is done.
	assign exec = aw_have_q & w_have_q & ~s_axi_bvalid & ~any_busy;
	assign hit_ctrl = awaddr_q == pcs_pkg::OFS_CTRL;
	assign hit_arg = awaddr_q == pcs_pkg::OFS_ARG;
	assign hit_cmd = awaddr_q == pcs_pkg::OFS_CMD;
	assign hit_status = awaddr_q == pcs_pkg::OFS_STATUS;
	assign w_known = hit_ctrl | hit_arg | hit_cmd | hit_status;
	assign wval = merge(32'h0000_0000, wdata_q, wstrb_q);
	assign op = (exec & hit_cmd) ? pcs_pkg::pcs_op_t'(wval[3:0])
		: pcs_pkg::OP_NOP;
	assign cmd_unit = wval[pcs_pkg::CMD_UNIT_LSB +: 3];
	assign pipe_media = ctrl_q[pcs_pkg::CTRL_PIPE_BIT];
	assign pipe_mask = pipe_media ? pcs_pkg::MASK_MEDIA_PIPE
		: pcs_pkg::MASK_DRAW_PIPE;
	// The streamer unit cannot be disabled.
	assign unit_en = ctrl_q[N-1:0] | pcs_pkg::MASK_STREAMER;
	assign live_mask = (pipe_mask & unit_en) | pcs_pkg::MASK_STREAMER;

	// Ordering checks; a stale unit has changed state without a fence.
	assign cs_ok = cs_state_q & cs_fenced_q & ~stale_q[0];
	assign const_ok = cs_ok & ~|(stale_q & live_mask); // [R13] [R09]
	assign draw_ok = ~pipe_media & common_q & draw_st_q & const_ok; // [R14]
	assign media_ok = pipe_media & common_q & media_st_q & const_ok; // [R15]
	assign viol_set = (op == pcs_pkg::OP_DRAW & ~draw_ok) // [R17] [R16]
		| (op == pcs_pkg::OP_MEDIA_WORK & ~media_ok)
		| (op == pcs_pkg::OP_CONST_LOAD & ~const_ok);
	assign viol_clr = exec & hit_status & wval[pcs_pkg::ST_VIOL];

	// Fence goes to the streamer, then one cycle later down the pipe.
	assign unit_go = (fence_stage_q == 2'h1) ? pcs_pkg::MASK_STREAMER // [R03]
		: (fence_stage_q == 2'h2) ? pipe_mask : 6'h00;

	// ---------------------------------------------------------------
	// Per-unit allocators
	// ---------------------------------------------------------------
	for (genvar u = 0; u < N; u++) begin : g_unit
		pcs_unit_alloc u_alloc (
			.aclk(aclk),
			.aresetn(aresetn),
			.fence_go(unit_go[u]),
			.unit_en(unit_en[u]),
			.update_en(fence_mask_q[u]),
			.fence_val(fence_val_q),
			.entry_cnt(cnt_q[u]),
			.entry_size(size_q[u]),
			.busy(unit_busy[u]),
			.realloc(unit_realloc[u]),
			.held(unit_held[u]),
			.base(unit_base[u])
		);
	end

	// ---------------------------------------------------------------
	// Read decode
	// ---------------------------------------------------------------
	assign sel = ctrl_q[pcs_pkg::CTRL_SEL_LSB +: 3];
	assign cidx = ctrl_q[pcs_pkg::CTRL_IDX_LSB +: 4];
	assign ar_ofs = s_axi_araddr;
	assign status_w = {18'h0_0000, stale_q, cs_fenced_q, cs_state_q,
		media_st_q, draw_st_q, common_q, any_busy, const_valid_q, viol_q};
	assign r_known = (ar_ofs == pcs_pkg::OFS_CTRL)
		| (ar_ofs == pcs_pkg::OFS_ARG) | (ar_ofs == pcs_pkg::OFS_CMD)
		| (ar_ofs == pcs_pkg::OFS_STATUS) | (ar_ofs == pcs_pkg::OFS_HELD)
		| (ar_ofs == pcs_pkg::OFS_CONST);
	assign rd_word = (ar_ofs == pcs_pkg::OFS_CTRL) ? ctrl_q
		: (ar_ofs == pcs_pkg::OFS_ARG) ? arg_q
		: (ar_ofs == pcs_pkg::OFS_STATUS) ? status_w
		: (ar_ofs == pcs_pkg::OFS_HELD && sel < 3'(N))
			? {unit_base[sel], 8'h00, unit_held[sel]}
		: (ar_ofs == pcs_pkg::OFS_CONST) ? const_mem[cidx]
		: 32'h0000_0000;

	// ---------------------------------------------------------------
	// Write path of the bus slave
	// ---------------------------------------------------------------
	// Address and data are caught independently, in either order.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_have_q <= 1'b0;
			w_have_q <= 1'b0;
			awaddr_q <= 8'h00;
			wdata_q <= 32'h0000_0000;
			wstrb_q <= 4'h0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= pcs_pkg::RESP_OKAY;
		end else begin
			if (s_axi_awvalid & s_axi_awready) begin
				awaddr_q <= s_axi_awaddr;
				aw_have_q <= 1'b1;
			end else if (exec) begin
				aw_have_q <= 1'b0;
			end
			if (s_axi_wvalid & s_axi_wready) begin
				wdata_q <= s_axi_wdata;
				wstrb_q <= s_axi_wstrb;
				w_have_q <= 1'b1;
			end else if (exec) begin
				w_have_q <= 1'b0;
			end
			if (exec) begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= w_known ? pcs_pkg::RESP_OKAY
					: pcs_pkg::RESP_SLVERR;
			end else if (s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	// Ready drops while a half is held, giving back-pressure to the master.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_awready <= 1'b0;
			s_axi_wready <= 1'b0;
		end else begin
			s_axi_awready <= ~aw_have_q & ~(s_axi_awvalid & s_axi_awready);
			s_axi_wready <= ~w_have_q & ~(s_axi_wvalid & s_axi_wready);
		end
	end

	// ---------------------------------------------------------------
	// Read path of the bus slave
	// ---------------------------------------------------------------
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0000_0000;
			s_axi_rresp <= pcs_pkg::RESP_OKAY;
		end else begin
			s_axi_arready <= ~s_axi_rvalid & ~s_axi_arready;
			if (s_axi_arvalid & s_axi_arready) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rdata <= rd_word;
				s_axi_rresp <= r_known ? pcs_pkg::RESP_OKAY
					: pcs_pkg::RESP_SLVERR;
			end else if (s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
		end
	end

	// ---------------------------------------------------------------
	// Control registers and fence sequencing
	// ---------------------------------------------------------------
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ctrl_q <= pcs_pkg::CTRL_RESET;
			arg_q <= 32'h0000_0000;
			fence_stage_q <= 2'h0;
			fence_mask_q <= 6'h00;
			fence_val_q <= 16'h0000;
		end else begin
			if (exec & hit_ctrl) begin
				ctrl_q <= merge(ctrl_q, wdata_q, wstrb_q);
			end
			if (exec & hit_arg) begin
				arg_q <= merge(arg_q, wdata_q, wstrb_q);
			end
			if (op == pcs_pkg::OP_FENCE) begin
				fence_val_q <= arg_q[15:0];
				fence_mask_q <= arg_q[pcs_pkg::ARG_MASK_LSB +: 6];
				fence_stage_q <= 2'h1;
			end else if (fence_stage_q == 2'h1) begin
				fence_stage_q <= 2'h2;
			end else begin
				fence_stage_q <= 2'h0;
			end
		end
	end

	// Entry state commands store values only; no reallocation starts here.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			for (int u = 0; u < N; u++) begin
				cnt_q[u] <= 8'h00;
				size_q[u] <= 8'h00;
				thr_q[u] <= 8'h00;
			end
		end else if (op == pcs_pkg::OP_STREAMER_STATE) begin // [R07] [R08]
			cnt_q[0] <= arg_q[7:0];
			size_q[0] <= arg_q[pcs_pkg::ARG_SIZE_LSB +: 8];
		end else if ((op == pcs_pkg::OP_DRAW_STATE_PTR
			|| op == pcs_pkg::OP_MEDIA_STATE_PTR)
			&& cmd_unit != pcs_pkg::UNIT_STREAMER && cmd_unit < 3'(N)) begin
			cnt_q[cmd_unit] <= arg_q[7:0]; // [R07]
			size_q[cmd_unit] <= arg_q[pcs_pkg::ARG_SIZE_LSB +: 8];
			thr_q[cmd_unit] <= arg_q[pcs_pkg::ARG_THR_LSB +: 8];
		end
	end

	// ---------------------------------------------------------------
	// Ordering state
	// ---------------------------------------------------------------
	// A count or size change, or a thread-limit change on the geometry or clipper unit, marks the unit stale; a realloc of that unit clears it.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			stale_q <= '0;
		end else begin
			for (int u = 0; u < N; u++) begin
				if (op == pcs_pkg::OP_STREAMER_STATE && u == 0
					&& arg_q[15:0] != {size_q[0], cnt_q[0]}) begin
					stale_q[u] <= 1'b1; // [R09]
				end else if ((op == pcs_pkg::OP_DRAW_STATE_PTR
					|| op == pcs_pkg::OP_MEDIA_STATE_PTR)
					&& 32'(cmd_unit) == u && u != 0
					&& (arg_q[15:0] != {size_q[u], cnt_q[u]}
					|| ((3'(u) == pcs_pkg::UNIT_GEOMETRY
					|| 3'(u) == pcs_pkg::UNIT_CLIPPER)
					&& arg_q[pcs_pkg::ARG_THR_LSB +: 8] != thr_q[u]))) begin
					stale_q[u] <= 1'b1; // [R09]
				end else if (unit_realloc[u]) begin
					stale_q[u] <= 1'b0;
				end
			end
		end
	end

	// Sticky violation flag; a new violation wins over a clear.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			viol_q <= 1'b0;
			common_q <= 1'b0;
			draw_st_q <= 1'b0;
			media_st_q <= 1'b0;
			cs_state_q <= 1'b0;
			cs_fenced_q <= 1'b0;
		end else begin
			viol_q <= viol_set | (viol_q & ~viol_clr); // [R17]
			common_q <= common_q | (op == pcs_pkg::OP_COMMON_STATE);
			draw_st_q <= draw_st_q | (op == pcs_pkg::OP_DRAW_STATE_PTR);
			media_st_q <= media_st_q | (op == pcs_pkg::OP_MEDIA_STATE_PTR);
			cs_state_q <= cs_state_q | (op == pcs_pkg::OP_STREAMER_STATE);
			cs_fenced_q <= cs_fenced_q | unit_realloc[0];
		end
	end

	// Constant region; a streamer realloc voids it until reloaded.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			const_valid_q <= 1'b0;
		end else if (unit_realloc[0]) begin
			const_valid_q <= 1'b0; // [R11]
		end else if (op == pcs_pkg::OP_CONST_LOAD && const_ok) begin
			const_valid_q <= 1'b1;
		end
	end

	// Constant data lands only when the streamer region is established.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			const_mem <= '{default: 32'h0000_0000};
		end else if (op == pcs_pkg::OP_CONST_LOAD && const_ok) begin
			const_mem[wval[11:8]] <= arg_q; // [R12]
		end
	end
endmodule // pcs_sequencer

//--- testbench/pcs_sequencer_assertions.sv
// Purpose: Bus checks on the command sequencer ports.
// Assumes: One clock, synchronous active-low reset.
// Notes: Fence work may hold a write answer up to 257 cycles.
`timescale 1ns/1ps
module pcs_sequencer_assertions (
	// Clock and reset.
	input wire logic aclk,
	input wire logic aresetn,
	// Write side.
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic [1:0] s_axi_bresp,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	// Read side.
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic [1:0] s_axi_rresp,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready
);
	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);

	// Marks a write to an unmapped word until its answer is taken.
	logic unm_q, unm_d, aw_hs, ar_hs;
	assign aw_hs = s_axi_awvalid && s_axi_awready;
	assign ar_hs = s_axi_arvalid && s_axi_arready;
	assign unm_d = aw_hs ? (s_axi_awaddr > 8'h17) :
		((s_axi_bvalid && s_axi_bready) ? 1'b0 : unm_q);
	always_ff @(posedge aclk) begin
		if (!aresetn) unm_q <= 1'b0;
		else unm_q <= unm_d;
	end

	// Answers stand until taken, and reads follow their address at once.
	AST_B_STANDS: assert property (s_axi_bvalid && !s_axi_bready |=>
		s_axi_bvalid && $stable(s_axi_bresp)) else $error("bresp moved");
	AST_R_STANDS: assert property (s_axi_rvalid && !s_axi_rready |=>
		s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp))
		else $error("read answer moved");
	AST_R_ANSWER: assert property (ar_hs |=> s_axi_rvalid)
		else $error("read answer late");
	AST_AR_GAP: assert property (ar_hs |=> !s_axi_arready)
		else $error("arready not dropped");
	AST_AR_BLOCK: assert property (s_axi_rvalid |-> !s_axi_arready)
		else $error("arready during answer");
	AST_R_UNMAPPED: assert property (ar_hs && s_axi_araddr > 8'h17 |=>
		s_axi_rresp == pcs_pkg::RESP_SLVERR && s_axi_rdata == 32'h0000_0000)
		else $error("unmapped read answer");
	AST_R_CMD_ZERO: assert property (ar_hs && s_axi_araddr == 8'h08 |=>
		s_axi_rdata == 32'h0000_0000) else $error("command word read back");
	AST_B_UNMAPPED: assert property (s_axi_bvalid && unm_q |->
		s_axi_bresp == pcs_pkg::RESP_SLVERR) else $error("unmapped write ok");
	// A fence must finish so the write answer comes within bound.
	AST_B_BOUND: assert property (aw_hs && s_axi_wvalid && s_axi_wready |->
		##[2:300] s_axi_bvalid) else $error("write answer missing");
endmodule // pcs_sequencer_assertions

bind pcs_sequencer pcs_sequencer_assertions u_chk (
	.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
	.s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
	.s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
	.s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
	.s_axi_rvalid, .s_axi_rready
);

//--- testbench/pcs_host_model.sv
// Purpose: Driver-side bus master that issues register accesses.
// Assumes: One write or one read under way at a time.
// Notes: Set slow to make the answer wait for a late ready.
`timescale 1ns/1ps
module pcs_host_model (
	// Clock.
	input wire logic aclk,
	// Write side.
	output logic [7:0] s_axi_awaddr,
	output logic s_axi_awvalid,
	input wire logic s_axi_awready,
	output logic [31:0] s_axi_wdata,
	output logic [3:0] s_axi_wstrb,
	output logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic [1:0] s_axi_bresp,
	input wire logic s_axi_bvalid,
	output logic s_axi_bready,
	// Read side.
	output logic [7:0] s_axi_araddr,
	output logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic [1:0] s_axi_rresp,
	input wire logic s_axi_rvalid,
	output logic s_axi_rready
);
	logic slow = 1'b0;

	// Idle bus at time zero.
	initial begin
		{s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wstrb, s_axi_wvalid,
			s_axi_bready, s_axi_araddr, s_axi_arvalid, s_axi_rready} = '0;
	end

	// Released payload is inverted so a stale value never looks valid.
	task automatic wr(input logic [7:0] a, input logic [31:0] d,
		output logic [1:0] r);
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_wstrb <= 4'hf;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= !slow;
		forever begin
			@(posedge aclk);
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
			if (s_axi_bvalid && s_axi_bready) break;
			if (s_axi_bvalid) s_axi_bready <= 1'b1;
		end
		r = s_axi_bresp;
		s_axi_bready <= 1'b0;
		s_axi_awaddr <= ~a;
		s_axi_wdata <= ~d;
	endtask

	task automatic rd(input logic [7:0] a, output logic [31:0] d,
		output logic [1:0] r);
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= !slow;
		forever begin
			@(posedge aclk);
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
			if (s_axi_rvalid && s_axi_rready) break;
			if (s_axi_rvalid) s_axi_rready <= 1'b1;
		end
		d = s_axi_rdata;
		r = s_axi_rresp;
		s_axi_rready <= 1'b0;
		s_axi_araddr <= ~a;
	endtask
endmodule // pcs_host_model

//--- testbench/pipeline_command_sequencer_tb.sv
// Purpose: Self-checking bench for the command sequencer.
// Assumes: Registers at the byte offsets of the package.
// Notes: Only units 0 and 2 are enabled in these runs.
`timescale 1ns/1ps
module pipeline_command_sequencer_tb;
	logic aclk = 1'b0;
	logic aresetn = 1'b0;
	logic [7:0] s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata;
	logic [3:0] s_axi_wstrb;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
	logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
	logic s_axi_rvalid, s_axi_rready;
	int n_fail = 0;
	int total_checks = 0;

	always #5 aclk = ~aclk;

	pcs_host_model u_host (.aclk, .s_axi_awaddr, .s_axi_awvalid,
		.s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
		.s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
		.s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
		.s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
	pcs_sequencer dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
		.s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
		.s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
		.s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
		.s_axi_rresp, .s_axi_rvalid, .s_axi_rready);

	// -----------------------------------------------------------------
	// Compare and access helpers
	// -----------------------------------------------------------------
	task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			n_fail++;
			$display("[FAIL] %0t word %h expected %h", $time, got, exp);
		end
	endtask

	task automatic chk_resp(input logic [1:0] got, input logic [1:0] exp);
		total_checks++;
		if (got !== exp) begin
			n_fail++;
			$display("[FAIL] %0t resp %h expected %h", $time, got, exp);
		end
	endtask

	// Reads a word and compares the bits under the mask.
	task automatic rd(input logic [7:0] a, input logic [31:0] m,
		input logic [31:0] exp);
		logic [31:0] d;
		logic [1:0] r;
		u_host.rd(a, d, r);
		chk_resp(r, pcs_pkg::RESP_OKAY);
		chk_word(d & m, exp);
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [1:0] r;
		u_host.wr(a, d, r);
		chk_resp(r, pcs_pkg::RESP_OKAY);
	endtask

	// ARG first: the command word starts the work.
	task automatic cmd(input pcs_pkg::pcs_op_t op, input logic [7:0] hi,
		input logic [31:0] arg);
		wr(pcs_pkg::OFS_ARG, arg);
		wr(pcs_pkg::OFS_CMD, {20'h0_0000, hi, op});
	endtask

	task automatic bare(input pcs_pkg::pcs_op_t op);
		cmd(op, 8'h00, 32'h0000_0000);
	endtask

	// The second write waits until fence work ends, so reads see it settled.
	task automatic fence(input logic [31:0] arg);
		cmd(pcs_pkg::OP_FENCE, 8'h00, arg);
		wr(pcs_pkg::OFS_ARG, arg);
	endtask

	task automatic held(input logic [31:0] exp);
		rd(pcs_pkg::OFS_HELD, 32'hffff_ffff, exp);
	endtask

	// Checks the sticky flag, then clears it by writing one.
	task automatic viol(input logic exp);
		rd(pcs_pkg::OFS_STATUS, 32'h0000_0001, {31'h0000_0000, exp});
		wr(pcs_pkg::OFS_STATUS, 32'h0000_0001);
	endtask

	// -----------------------------------------------------------------
	// Scenarios
	// -----------------------------------------------------------------
	task automatic t_reset;
		logic [31:0] d;
		logic [1:0] r;
		u_host.slow = 1'b1;
		rd(pcs_pkg::OFS_CTRL, 32'hffff_ffff, pcs_pkg::CTRL_RESET);
		rd(pcs_pkg::OFS_STATUS, 32'hffff_ffff, 32'h0000_0000);
		rd(pcs_pkg::OFS_CMD, 32'hffff_ffff, 32'h0000_0000);
		u_host.rd(8'h18, d, r);
		chk_resp(r, pcs_pkg::RESP_SLVERR);
		chk_word(d, 32'h0000_0000);
		u_host.wr(8'h1c, 32'h0000_0001, r);
		chk_resp(r, pcs_pkg::RESP_SLVERR);
		u_host.slow = 1'b0;
	endtask

	task automatic t_order;
		bare(pcs_pkg::OP_DRAW);
		viol(1'b1);
		cmd(pcs_pkg::OP_STREAMER_STATE, 8'h00, 32'h0000_0204);
		held(32'h0000_0000);
		cmd(pcs_pkg::OP_CONST_LOAD, 8'h00, 32'h1234_5678);
		viol(1'b1);
		rd(pcs_pkg::OFS_CONST, 32'hffff_ffff, 32'h0000_0000);
	endtask

	task automatic t_fence;
		fence(32'h0001_0100);
		held(32'h00f8_0004);
		cmd(pcs_pkg::OP_DRAW_STATE_PTR, 8'h02, 32'h0001_0403);
		fence(32'h0004_0200);
		wr(pcs_pkg::OFS_CTRL, 32'h0000_2001);
		held(32'h0000_0000);
		wr(pcs_pkg::OFS_CTRL, 32'h0000_2005);
		fence(32'h0004_0200);
		held(32'h01f4_0003);
		fence(32'h0000_0300);
		held(32'h01f4_0003);
		wr(pcs_pkg::OFS_CTRL, 32'h0000_2105);
		fence(32'h0004_0300);
		held(32'h01f4_0003);
		wr(pcs_pkg::OFS_CTRL, 32'h0000_0005);
		cmd(pcs_pkg::OP_STREAMER_STATE, 8'h00, 32'h0000_0202);
		held(32'h00f8_0004);
		fence(32'h0001_0100);
		held(32'h00fc_0002);
	endtask

	task automatic t_const;
		cmd(pcs_pkg::OP_CONST_LOAD, 8'h30, 32'hdead_beef);
		wr(pcs_pkg::OFS_CTRL, 32'h0003_0005);
		rd(pcs_pkg::OFS_CONST, 32'hffff_ffff, 32'hdead_beef);
		rd(pcs_pkg::OFS_STATUS, 32'h0000_0002, 32'h0000_0002);
		fence(32'h0001_0100);
		rd(pcs_pkg::OFS_STATUS, 32'h0000_0002, 32'h0000_0000);
		cmd(pcs_pkg::OP_CONST_LOAD, 8'h30, 32'hdead_beef);
	endtask

	task automatic t_work;
		bare(pcs_pkg::OP_COMMON_STATE);
		bare(pcs_pkg::OP_DRAW_STATE);
		bare(pcs_pkg::OP_DRAW);
		viol(1'b0);
		cmd(pcs_pkg::OP_DRAW_STATE_PTR, 8'h02, 32'h0001_0405);
		bare(pcs_pkg::OP_DRAW);
		viol(1'b1);
		fence(32'h0004_0300);
		bare(pcs_pkg::OP_DRAW);
		viol(1'b0);
		bare(pcs_pkg::OP_MEDIA_WORK);
		viol(1'b1);
	endtask

	// -----------------------------------------------------------------
	// Run control
	// -----------------------------------------------------------------
	task automatic tally_and_finish;
		$display("checks %0d failures %0d", total_checks, n_fail);
		if (n_fail == 0 && total_checks > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask

	// Main sequence after a five-cycle reset.
	initial begin
		repeat (5) @(posedge aclk);
		aresetn <= 1'b1;
		repeat (2) @(posedge aclk);
		t_reset;
		t_order;
		t_fence;
		t_const;
		t_work;
		tally_and_finish;
	end

	// Cuts a hang short; the tests need a few hundred cycles.
	initial begin
		repeat (20000) @(posedge aclk);
		n_fail++;
		$display("[FAIL] %0t watchdog expired", $time);
		tally_and_finish;
	end
endmodule // pipeline_command_sequencer_tb
